/* File: rtc_top.sv */
// real-time clock: prescaler, 20-bit divider, 32-bit counter, alarm, AXI4-Lite regs
// assumes mclk is the oscillator-derived block clock; osc pins are async inputs
`include "rtc_defines.svh"
module rtc_top
   import rtc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        lowpower_osc_input,
   input  wire logic        powerdown_req,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             tick_interrupt_request,
   output logic             alarm_interrupt_request,
   output logic             fast_ext_irq,
   output logic             irq,
   output logic             wake_req,
   output logic             main_osc_enable,
   output logic             lowpower_osc_enable,
   output logic             lowpower_sel
);
   logic [31:0] timekeeper_control_reg;
   logic [19:0] tick_reload_register_reg;
   logic [19:0] div_reg;
   logic [5:0]  pre_reg;
   logic [31:0] cnt_reg;
   logic [31:0] alarm_reg;
   logic [31:0] ntick_reg;
   logic [31:0] ncnt_reg;
   logic [2:0]  stat_reg;
   logic [2:0]  ien_reg;
   logic [2:0]  lp_sync_reg;
   logic [7:0]  lp_edges_reg;
   logic        lp_done_reg;
   logic        alarm_hit_reg;
   rtc_pwr_type pwr_reg;
   rtc_evt_type evt;
   logic        en;
   logic        run;
   logic        pre_tc;
   logic        tick;
   logic        match;
   // bus holding registers
   logic        aw_full_reg;
   logic        w_full_reg;
   logic [7:0]  awa_reg;
   logic        aw_bad_reg;
   logic [31:0] wd_reg;
   logic [3:0]  ws_reg;
   logic        wr_go;
   logic        clr_wr;
   logic [31:0] clr_val;

   assign en    = timekeeper_control_reg[`RTC_CTRL_EN];
   // counter freezes in power-down only when keep-running is clear
   assign run   = en & ~(pwr_reg != RTC_RUN & ~timekeeper_control_reg[`RTC_CTRL_KEEP]);
   assign pre_tc = run & (pre_reg == `RTC_PRE_DIV);
   assign tick  = pre_tc & (div_reg == 20'h00000);
   assign match = en & (cnt_reg == alarm_reg);
   assign evt.tick  = tick;
   assign evt.ntick = tick & (ntick_reg != 32'h00000000) & (ncnt_reg == 32'h00000001);
   assign evt.alarm = match & ~alarm_hit_reg;

   // low-power oscillator detection: count filtered edges after reset
   // several edges reject a floating or noisy pin, at the cost of a short delay
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lp_sync_reg  <= 3'h0;
      end else begin
         lp_sync_reg  <= {lp_sync_reg[1:0], lowpower_osc_input};
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lp_edges_reg <= 8'h00;
         lp_done_reg  <= 1'b0;
      end else if (!lp_done_reg && (lp_sync_reg[2] != lp_sync_reg[1])) begin
         lp_edges_reg <= lp_edges_reg + 8'h01;
         if (lp_edges_reg == `RTC_DET_CNT - 8'h01) begin
            lp_done_reg <= 1'b1;
         end
      end
   end

   // prescaler and reloadable divider; the tick reloads the 20-bit stage from the reload register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pre_reg <= 6'h00;
      end else if (run) begin
         pre_reg <= pre_reg + 6'h01;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_reg <= `RTC_RELOAD_RST;
      end else if (wr_go && awa_reg == `RTC_OFS_RELOAD) begin
         div_reg <= wd_reg[19:0];
      end else if (tick) begin
         div_reg <= tick_reload_register_reg;
      end else if (pre_tc) begin
         div_reg <= div_reg - 20'h00001;
      end
   end

   // time counter wraps naturally at 32 bits
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 32'h00000000;
      end else if (wr_go && awa_reg == `RTC_OFS_CNT) begin
         cnt_reg <= wd_reg;
      end else if (tick) begin
         cnt_reg <= cnt_reg + 32'h00000001;
      end
   end
   // alarm fires once per match, not every cycle the values stay equal
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         alarm_hit_reg <= 1'b0;
      end else begin
         alarm_hit_reg <= match;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ncnt_reg <= 32'h00000000;
      end else if (wr_go && awa_reg == `RTC_OFS_NTICK) begin
         ncnt_reg <= wd_reg;
      end else if (tick) begin
         ncnt_reg <= (ncnt_reg <= 32'h00000001) ? ntick_reg : ncnt_reg - 32'h00000001;
      end
   end

   // power state: enter on request, wake on enabled event if allowed
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pwr_reg <= RTC_RUN;
      end else begin
         unique case (pwr_reg)
            RTC_RUN: begin
               if (powerdown_req) begin
                  pwr_reg <= RTC_PWD;
               end
            end
            RTC_PWD: begin
               // wake needs both the wake bit and a pending enabled event
               if (timekeeper_control_reg[`RTC_CTRL_WAKE] && (stat_reg & ien_reg) != 3'h0) begin
                  pwr_reg <= RTC_WAKE;
               end else if (!powerdown_req) begin
                  pwr_reg <= RTC_RUN;
               end
            end
            RTC_WAKE: begin
               if (!powerdown_req) begin
                  pwr_reg <= RTC_RUN;
               end
            end
            default: begin
               pwr_reg <= RTC_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tick_interrupt_request  <= 1'b0;
         alarm_interrupt_request <= 1'b0;
         fast_ext_irq            <= 1'b0;
         irq                     <= 1'b0;
         wake_req                <= 1'b0;
         main_osc_enable         <= 1'b1;
         lowpower_osc_enable     <= 1'b1;
         lowpower_sel            <= 1'b0;
      end else begin
         tick_interrupt_request  <= (evt.tick | evt.ntick) & ien_reg[`RTC_ST_TICK];
         alarm_interrupt_request <= evt.alarm & ien_reg[`RTC_ST_ALARM];
         fast_ext_irq <= (timekeeper_control_reg[`RTC_CTRL_FSEL_T] & (evt.tick | evt.ntick))
                       | (timekeeper_control_reg[`RTC_CTRL_FSEL_A] & evt.alarm);
         irq          <= (stat_reg & ien_reg) != 3'h0;
         wake_req     <= (pwr_reg == RTC_WAKE);
         lowpower_sel <= lp_done_reg;
         if (pwr_reg == RTC_RUN) begin
            main_osc_enable     <= 1'b1;
            lowpower_osc_enable <= 1'b1;
         end else begin
            // the low-power path keeps the counter alive with the main osc stopped
            main_osc_enable     <= en & ~lp_done_reg
                                 & ~timekeeper_control_reg[`RTC_CTRL_OSCOFF];
            lowpower_osc_enable <= en & lp_done_reg
                                 & ~timekeeper_control_reg[`RTC_CTRL_OSCOFF];
         end
      end
   end

   // sticky status; a set in the clear cycle wins
   assign clr_wr  = wr_go && awa_reg == `RTC_OFS_CLR;
   assign clr_val = clr_wr ? wd_reg : 32'h00000000;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stat_reg <= 3'h0;
      end else begin
         stat_reg <= (stat_reg & ~clr_val[2:0]) | {evt.alarm, evt.ntick, evt.tick};
      end
   end

   // AXI4-Lite write: address and data taken in either order
   assign wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         awa_reg       <= 8'h00;
         aw_bad_reg    <= 1'b0;
         wd_reg        <= 32'h00000000;
         ws_reg        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         s_axi_awready <= ~aw_full_reg & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready  <= ~w_full_reg & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awa_reg     <= s_axi_awaddr[7:0];
            // keep the high-address error with the address; the master may move on
            aw_bad_reg  <= s_axi_awaddr[31:8] != 24'h000000;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wd_reg     <= s_axi_wdata;
            ws_reg     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awa_reg > `RTC_OFS_IEN || awa_reg[1:0] != 2'b00
                             || aw_bad_reg) ? 2'b10 : 2'b00;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // software registers; partial strobes are ignored here, though the count, divider and n-tick count still load on any strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timekeeper_control_reg   <= 32'h00000000;
         tick_reload_register_reg <= `RTC_RELOAD_RST;
         alarm_reg                <= 32'hFFFFFFFF;
         ntick_reg                <= 32'h00000000;
         ien_reg                  <= 3'h0;
      end else if (wr_go && ws_reg == 4'hF) begin
         // partial-strobe writes still answer OKAY, so software sees no error
         case (awa_reg)
            `RTC_OFS_CTRL: begin
               timekeeper_control_reg   <= {26'h0, wd_reg[5:0]};
            end
            `RTC_OFS_RELOAD: begin
               tick_reload_register_reg <= wd_reg[19:0];
            end
            `RTC_OFS_ALARM: begin
               alarm_reg                <= wd_reg;
            end
            `RTC_OFS_NTICK: begin
               ntick_reg                <= wd_reg;
            end
            `RTC_OFS_IEN: begin
               ien_reg                  <= wd_reg[2:0];
            end
            default: ;
         endcase
      end
   end

   // AXI4-Lite read, one cycle answer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'b00;
            // an unmapped offset answers with a slave error and zero data
            case (s_axi_araddr[7:0])
               `RTC_OFS_CTRL: begin
                  s_axi_rdata <= timekeeper_control_reg;
               end
               `RTC_OFS_RELOAD: begin
                  s_axi_rdata <= {12'h000, tick_reload_register_reg};
               end
               `RTC_OFS_DIV: begin
                  s_axi_rdata <= {6'h00, div_reg, pre_reg};
               end
               `RTC_OFS_CNT: begin
                  s_axi_rdata <= cnt_reg;
               end
               `RTC_OFS_ALARM: begin
                  s_axi_rdata <= alarm_reg;
               end
               `RTC_OFS_NTICK: begin
                  s_axi_rdata <= ntick_reg;
               end
               `RTC_OFS_STAT: begin
                  s_axi_rdata <= {29'h0, stat_reg};
               end
               `RTC_OFS_CLR: begin
                  s_axi_rdata <= 32'h00000000;
               end
               `RTC_OFS_IEN: begin
                  s_axi_rdata <= {29'h0, ien_reg};
               end
               `RTC_OFS_SRC: begin
                  s_axi_rdata <= {29'h0, pwr_reg == RTC_PWD, lp_done_reg, en};
               end
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
            if (s_axi_araddr[31:8] != 24'h000000) begin
               s_axi_rresp <= 2'b10;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : rtc_top

/* File: rtc_defines.svh */
// register offsets, reset values and field positions of the timekeeper block
// assumes inclusion by the top module only
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_OFS_CTRL        8'h00
`define RTC_OFS_RELOAD      8'h04
`define RTC_OFS_DIV         8'h08
`define RTC_OFS_CNT         8'h0C
`define RTC_OFS_ALARM       8'h10
`define RTC_OFS_NTICK       8'h14
`define RTC_OFS_STAT        8'h18
`define RTC_OFS_CLR         8'h1C
`define RTC_OFS_IEN         8'h20
`define RTC_OFS_SRC         8'h24
`define RTC_PRE_DIV         6'h3F
`define RTC_RELOAD_RST      20'h00000
`define RTC_CTRL_EN         0
`define RTC_CTRL_OSCOFF     1
`define RTC_CTRL_KEEP       2
`define RTC_CTRL_WAKE       3
`define RTC_CTRL_FSEL_T     4
`define RTC_CTRL_FSEL_A     5
`define RTC_ST_TICK         0
`define RTC_ST_NTICK        1
`define RTC_ST_ALARM        2
`define RTC_DET_CNT         8'h08
`endif

/* File: rtc_pkg.sv */
// types shared by the timekeeper block
// assumes rtc_defines.svh in the include path
package rtc_pkg;
   typedef struct packed {
      logic tick;
      logic ntick;
      logic alarm;
   } rtc_evt_type;
   typedef enum logic [2:0] {
      RTC_RUN   = 3'b001,
      RTC_PWD   = 3'b010,
      RTC_WAKE  = 3'b100
   } rtc_pwr_type;
endpackage : rtc_pkg

/* File: rtc_top_sva.sv */
// checker of the timekeeper ports: request pulses, interrupt level, bus answers, oscillators
// assumes binding onto rtc_top, one clock mclk and async active-high rst
module rtc_top_sva (
   input wire logic mclk,
   input wire logic rst,
   input wire logic powerdown_req,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tick_interrupt_request,
   input wire logic alarm_interrupt_request,
   input wire logic fast_ext_irq,
   input wire logic irq,
   input wire logic wake_req,
   input wire logic main_osc_enable,
   input wire logic lowpower_osc_enable,
   input wire logic lowpower_sel
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_tick_pulse: assert property (tick_interrupt_request |=> !tick_interrupt_request)
      else $error("tick request longer than one cycle");
   a_fast_pulse: assert property (fast_ext_irq |=> !fast_ext_irq)
      else $error("fast request longer than one cycle");
   a_tick_irq: assert property (tick_interrupt_request |-> ##[1:2] irq)
      else $error("tick request without interrupt level");
   a_alarm_irq: assert property (alarm_interrupt_request |-> ##[1:2] irq)
      else $error("alarm request without interrupt level");
   a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   a_main_osc_off: assert property ($fell(main_osc_enable) |-> powerdown_req)
      else $error("main oscillator stopped outside power-down");
   a_lp_osc_off: assert property ($fell(lowpower_osc_enable) |-> powerdown_req)
      else $error("low-power oscillator stopped outside power-down");
   a_source_sticky: assert property (lowpower_sel |=> lowpower_sel)
      else $error("low-power source dropped");
   a_wake_in_pwd: assert property ($rose(wake_req) |-> powerdown_req)
      else $error("wake outside power-down");
endmodule : rtc_top_sva
bind rtc_top rtc_top_sva i_rtc_top_sva (.mclk, .rst, .powerdown_req, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready, .tick_interrupt_request, .alarm_interrupt_request,
   .fast_ext_irq, .irq, .wake_req, .main_osc_enable, .lowpower_osc_enable, .lowpower_sel);

/* File: rtc_lp_osc.sv */
// low-power oscillator at the far side of the block
// assumes present comes from the bench and osc_en from the block
module rtc_lp_osc (
   input wire logic present,
   input wire logic osc_en,
   output logic     lp_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial lp_out = 1'b0;
   // phase unrelated to mclk; a stopped crystal rests low rather than holding its last level
   always #37 lp_out = (present && osc_en) ? !lp_out : 1'b0;
endmodule : rtc_lp_osc

/* File: rtc_tick_alarm_counter_test.sv */
// self-checking bench of the timekeeper: bus tasks, ticks, alarm, power-down, source select
// assumes rtc_top with its checker bound and the low-power oscillator model
module rtc_tick_alarm_counter_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rst, pd, lp_on, lp, awv, wv, bready, arv, rready;
   logic        awrdy, wrdy, bv, arrdy, rv, tick, alarm, fast, irq, wake, mosc, lposc, lpsel;
   logic [31:0] awaddr, wdata, araddr, rdata, seed, v, d;
   logic [1:0]  bresp, rresp, r;
   int          bad_count, checked, cyc, fast_n, n;
   rtc_top i_rtc_top (.mclk, .rst, .lowpower_osc_input(lp), .powerdown_req(pd),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rready), .tick_interrupt_request(tick), .alarm_interrupt_request(alarm),
      .fast_ext_irq(fast), .irq(irq), .wake_req(wake), .main_osc_enable(mosc),
      .lowpower_osc_enable(lposc), .lowpower_sel(lpsel));
   rtc_lp_osc i_rtc_lp_osc (.present(lp_on), .osc_en(lposc), .lp_out(lp));
   always #2.5 mclk = ~mclk;
   task automatic stop_test();
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // the ceiling leaves ample room over the thousand or so cycles the tests need
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (fast === 1'b1) fast_n <= fast_n + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [31:0] period(input logic [31:0] rl);
      return 32'h40 * (rl + 32'h1);
   endfunction : period
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      logic aw_ok = 1'b0;
      logic w_ok = 1'b0;
      @(posedge mclk);
      awaddr <= {24'h000000, a};
      wdata <= dat;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (awrdy === 1'b1) begin
            aw_ok = 1'b1;
            awv <= 1'b0;
         end
         if (wrdy === 1'b1) begin
            w_ok = 1'b1;
            wv <= 1'b0;
         end
      end
      while (bv !== 1'b1) @(posedge mclk);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, 32'h0);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] dat);
      @(posedge mclk);
      araddr <= {24'h000000, a};
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (arrdy !== 1'b1);
      arv <= 1'b0;
      while (rv !== 1'b1) @(posedge mclk);
      dat = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic wait_tick(output int cnt);
      cnt = 0;
      do begin
         @(posedge mclk);
         cnt++;
      end while (tick !== 1'b1);
   endtask : wait_tick
   // leaves power-down held so the caller can look further
   task automatic pwd(input logic [31:0] c, input logic m);
      @(posedge mclk);
      pd <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(8'h00, c);
      pd <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("main osc", mosc, m);
   endtask : pwd
   initial begin
      {mclk, pd, lp_on, awv, wv, bready, arv, rready} = 8'h00;
      {awaddr, wdata, araddr} = 96'h0;
      rst = 1'b1;
      seed = 32'h00000022;
      {bad_count, checked, cyc, fast_n} = 128'h0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h10, d);
      chk("alarm reset", d, 32'hFFFFFFFF);
      rd(8'h24, d);
      chk("source reset", d & 32'h2, 32'h0);
      rd(8'h30, d);
      chk("unmapped", {30'h0, r}, 32'h2);
      $display("test reset done");
      wr(8'h20, 32'h7);
      wr(8'h00, 32'h11);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 32'h0 : (rnd() & 32'h3);
         wr(8'h04, v);
         wait_tick(n);
         wait_tick(n);
         chk("tick period", n, period(v));
      end
      chk("fast seen", fast_n > 0, 32'h1);
      rd(8'h08, d);
      rd(8'h08, v);
      chk("timer moves", d != v, 32'h1);
      $display("test tick done");
      wr(8'h00, 32'h0);
      wr(8'h20, 32'h0);
      repeat (2) @(posedge mclk);
      chk("irq masked", irq, 32'h0);
      wr(8'h20, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq pending", irq, 32'h1);
      wr(8'h1C, 32'h7);
      repeat (2) @(posedge mclk);
      chk("irq cleared", irq, 32'h0);
      $display("test irq done");
      v = rnd();
      wr(8'h0C, v);
      rd(8'h0C, d);
      chk("preset", d, v);
      wr(8'h20, 32'h7);
      wr(8'h10, v + 32'h2);
      wr(8'h00, 32'h21);
      while (alarm !== 1'b1) @(posedge mclk);
      rd(8'h0C, d);
      chk("alarm count", d, v + 32'h2);
      wr(8'h10, 32'h1);
      wr(8'h0C, 32'hFFFFFFFF);
      while (alarm !== 1'b1) @(posedge mclk);
      rd(8'h0C, d);
      chk("wrap", d, 32'h1);
      rd(8'h18, d);
      chk("alarm status", d & 32'h4, 32'h4);
      wr(8'h1C, 32'h7);
      wr(8'h14, 32'h2);
      wait_tick(n);
      rd(8'h18, d);
      chk("ntick early", d & 32'h2, 32'h0);
      wait_tick(n);
      rd(8'h18, d);
      chk("ntick due", d & 32'h2, 32'h2);
      $display("test counter done");
      pwd(32'h0, 1'b0);
      chk("lp osc", lposc, 32'h0);
      pwd(32'h3, 1'b0);
      pwd(32'h19, 1'b1);
      while (wake !== 1'b1) @(posedge mclk);
      chk("wake", wake, 32'h1);
      $display("test power-down done");
      @(posedge mclk);
      pd <= 1'b0;
      lp_on <= 1'b1;
      while (lpsel !== 1'b1) @(posedge mclk);
      rd(8'h24, d);
      chk("lp source", d & 32'h2, 32'h2);
      pwd(32'h1, 1'b0);
      $display("test low-power done");
      stop_test();
   end
endmodule : rtc_tick_alarm_counter_test
